// *** src/sas_pkg.sv ***
/*
 * sas_pkg: shared constants for the converter sequencer.
 * assumes one 250 MHz peripheral clock; all timing derived from its cycles.
 */
package sas_pkg;
    localparam int SAS_CLK_HZ = 250000000;
    localparam int SAS_MIN_ADC_HZ = 125000;
    // largest division that still keeps the converter clock at 125 kHz
    localparam int SAS_MAX_DIV = SAS_CLK_HZ / SAS_MIN_ADC_HZ;
    localparam int SAS_DATA_W = 12;
    localparam int SAS_RES_W = 16;
    localparam int SAS_CLOCK_DIVIDER_SELECT_W = 4;
    localparam int SAS_ACC_SEL_W = 3;
    localparam int SAS_DLY_W = 4;
    localparam int SAS_LEN_W = 8;
    localparam int SAS_INIT_W = 8;
    localparam int SAS_STARTUP_PER = 2;
    localparam int SAS_FORMAT_PER = 2;
    localparam int SAS_SAMPLE_ADC = 2;
    // 13.5 converter cycles held as half cycles
    localparam int SAS_CONV_HALF = 27;
    localparam int SAS_LEFT_SHIFT = 4;
    // low bits dropped from the raw word in 10-bit resolution
    localparam int SAS_TEN_DROP = 2;
    localparam logic [15:0] SAS_RES_RESET = 16'h0000;
    typedef enum logic [5:0] {
        SAS_IDLE = 6'b000001,
        SAS_START = 6'b000010,
        SAS_INIT = 6'b000100,
        SAS_SAMPLE = 6'b001000,
        SAS_CONV = 6'b010000,
        SAS_FORMAT = 6'b100000
    } sas_state_t;
endpackage : sas_pkg

// *** src/sas_prescaler.sv ***
/*
 * sas_prescaler: converter clock tick generator.
 * assumes clr_in is high whenever no conversion runs; emits half-period ticks.
 */
module sas_prescaler
    import sas_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic clr_in,
    input wire logic [SAS_CLOCK_DIVIDER_SELECT_W-1:0] sel_in,
    output logic half_tick_out
);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [15:0] half_lim;

    // division is 2^(sel+1); a half period is 2^sel peripheral cycles
    always_comb begin
        half_lim = 16'h0001 << sel_in;
        cnt_d = cnt_q + 16'h0001;
        if (clr_in || cnt_d == half_lim) begin // R4 R6
            cnt_d = 16'h0000;
        end
    end

    assign half_tick_out = !clr_in && (cnt_q + 16'h0001 == half_lim);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule : sas_prescaler

// *** src/sas_sequencer.sv ***
/*
 * sas_sequencer: start, delay, sample, convert and format sequencing with
 * accumulation and result formatting. assumes SAMPLE_IN carries the raw
 * conversion word when the convert phase ends, and that the event input
 * comes from another domain.
 */
module sas_sequencer
    import sas_pkg::*;
// Notes on behaviour
// (R1) free-running starts only after software writes start-conversion one; here an enabled event edge also starts it
// (R2) free-running relaunches the next cycle right after the last ends
// (R3) converter clock is divided from peripheral clock by select field
// (R4) prescaler counter restarts at the start of every conversion
// (R5) conversion begins one peripheral cycle after a trigger
// (R6) prescaler held in reset while idle; trigger delay at most two
// (R7) phases: start-up, sample two, convert 13.5, format two cycles
// (R8) on completion result register loaded and ready flag set
// (R9) accumulate chosen sample count; start bit stays set throughout
// (R10) free-running raises ready event and flag after every conversion
// (R11) software changes settings only after free-running is stopped
// (R12) sampling lasts two plus delay plus length converter cycles
// (R13) nonzero init delay holds off sampling for that many cycles
// (R14) results go to a 16-bit register, 0..4095 or 0..1023
// (R15) differential results two's complement and sign-extended
// (R16) right-aligned by default; left-align puts eight MSBs in high byte; here 10-bit sums of 32 or more samples end below bit 15
// (R17) start-conversion bit reads one while a conversion runs
// (R18) enabled rising event edge triggers and sets start bit
// (R19) ready flag set on completion even with interrupt disabled
// (R20) software clears ready flag by writing one; request holds till then
(
    input wire logic SYS_CLK_IN,
    input wire logic RESETN_IN,
    input wire logic START_CONVERSION_BIT_WR_IN,
    input wire logic START_EVENT_IN,
    input wire logic START_EVENT_INPUT_ENABLE_IN,
    input wire logic FREE_RUN_IN,
    input wire logic DIFFERENTIAL_IN,
    input wire logic RES_10BIT_IN,
    input wire logic LEFT_ALIGN_BIT_IN,
    input wire logic [SAS_CLOCK_DIVIDER_SELECT_W-1:0] CLOCK_DIVIDER_SELECT_IN,
    input wire logic [SAS_ACC_SEL_W-1:0] ACCUMULATE_COUNT_SELECT_IN,
    input wire logic [SAS_DLY_W-1:0] SAMPLING_DELAY_FIELD_IN,
    input wire logic [SAS_LEN_W-1:0] SAMPLE_LENGTH_FIELD_IN,
    input wire logic [SAS_INIT_W-1:0] INIT_DELAY_FIELD_IN,
    input wire logic RESULT_READY_INT_ENABLE_IN,
    input wire logic RESULT_READY_CLEAR_IN,
    input wire logic [SAS_DATA_W-1:0] SAMPLE_IN,
    output logic START_CONVERSION_BIT_OUT,
    output logic SAMPLING_OUT,
    output logic [SAS_RES_W-1:0] CONVERSION_RESULT_REG_OUT,
    output logic RESULT_READY_FLAG_OUT,
    output logic RESULT_READY_EVENT_OUT,
    output logic RESULT_READY_IRQ_OUT
);
    if (SAS_CLOCK_DIVIDER_SELECT_W > 15 || SAS_RES_W != 16) begin : g_bad_width
        $error("sas_sequencer: unsupported width");
    end

    sas_state_t st_q, st_d;
    logic ev_m_q, ev_s_q, ev_p_q;
    logic busy_q, busy_d;
    // ten bits: longest sampling phase is (2 + 15 + 255) * 2 half ticks
    logic [9:0] cnt_q, cnt_d;
    logic [7:0] smp_q, smp_d;
    logic [19:0] acc_q, acc_d;
    logic [15:0] res_q, res_d;
    logic rdy_q, rdy_d;
    logic evo_q, evo_d;
    logic half_tick;
    logic trig;
    logic [7:0] n_samples;
    logic [9:0] sample_halves;

    // sign- or zero-extend one sample to accumulator width
    function automatic logic [19:0] extend(input logic [11:0] v,
                                          input logic diff,
                                          input logic ten);
        logic [11:0] x;
        x = ten ? {2'b00, v[11:2]} : v;
        if (diff && ten) begin
            extend = {{10{v[11]}}, v[11:2]}; // R15
        end else if (diff) begin
            extend = {{8{x[11]}}, x}; // R15
        end else begin
            extend = {8'h00, x}; // R14
        end
    endfunction : extend

    // fit the sum into 16 bits: truncate above 16 samples, then align so
    // the eight top bits of a 12-bit word, or of a 10-bit sum of up to 16 samples, land in the high byte
    function automatic logic [15:0] fmt(input logic [19:0] a,
                                       input logic [2:0] sel,
                                       input logic left,
                                       input logic ten);
        logic [19:0] t;
        logic [15:0] r;
        int sh;
        sh = SAS_LEFT_SHIFT + (ten ? SAS_TEN_DROP : 0) - int'(sel);
        t = (sel > 3'd4) ? (a >>> (sel - 3'd4)) : a;
        r = t[15:0];
        if (left && sh > 0) begin
            r = r << sh; // R16
        end
        fmt = r;
    endfunction : fmt

    sas_prescaler u_clock_divider_select (
        .clk_in(SYS_CLK_IN),
        .rst_n_in(RESETN_IN),
        .clr_in(st_q == SAS_IDLE || st_q == SAS_START), // R6 R4
        .sel_in(CLOCK_DIVIDER_SELECT_IN), // R3
        .half_tick_out(half_tick)
    );

    // two-flop synchroniser, then edge detect on the second stage only
    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            ev_m_q <= 1'b0;
            ev_s_q <= 1'b0;
            ev_p_q <= 1'b0;
        end else begin
            ev_m_q <= START_EVENT_IN;
            ev_s_q <= ev_m_q;
            ev_p_q <= ev_s_q;
        end
    end

    assign trig = START_CONVERSION_BIT_WR_IN ||
                  (START_EVENT_INPUT_ENABLE_IN && ev_s_q && !ev_p_q); // R18 R1
    assign n_samples = 8'h01 << ACCUMULATE_COUNT_SELECT_IN;
    // counts are in converter half-periods
    assign sample_halves = 10'((SAS_SAMPLE_ADC + SAMPLING_DELAY_FIELD_IN
                               + SAMPLE_LENGTH_FIELD_IN) * 2); // R12

    always_comb begin
        st_d = st_q;
        busy_d = busy_q;
        cnt_d = cnt_q;
        smp_d = smp_q;
        acc_d = acc_q;
        res_d = res_q;
        rdy_d = rdy_q;
        evo_d = 1'b0;
        if (RESULT_READY_CLEAR_IN) begin
            rdy_d = 1'b0; // R20
        end
        case (st_q)
            SAS_IDLE: begin
                if (trig) begin
                    st_d = SAS_START; // R5
                    busy_d = 1'b1; // R17 R18
                    acc_d = 20'h00000;
                    smp_d = 8'h00;
                    cnt_d = 10'h000;
                end
            end
            SAS_START: begin
                cnt_d = 10'h000;
                st_d = (INIT_DELAY_FIELD_IN != 8'h00) ? SAS_INIT
                                                       : SAS_SAMPLE; // R13
            end
            SAS_INIT: begin
                if (half_tick) begin
                    cnt_d = cnt_q + 10'h001;
                    if (cnt_q + 10'h001 ==
                        {1'b0, INIT_DELAY_FIELD_IN, 1'b0}) begin
                        st_d = SAS_SAMPLE; // R13
                        cnt_d = 10'h000;
                    end
                end
            end
            SAS_SAMPLE: begin
                if (half_tick) begin
                    cnt_d = cnt_q + 10'h001;
                    if (cnt_q + 10'h001 == sample_halves) begin
                        st_d = SAS_CONV; // R7 R12
                        cnt_d = 10'h000;
                    end
                end
            end
            SAS_CONV: begin
                if (half_tick) begin
                    cnt_d = cnt_q + 10'h001;
                    if (cnt_q + 10'h001 == 10'(SAS_CONV_HALF)) begin
                        st_d = SAS_FORMAT; // R7
                        cnt_d = 10'h000;
                        acc_d = acc_q + extend(SAMPLE_IN, DIFFERENTIAL_IN,
                                               RES_10BIT_IN); // R9
                        smp_d = smp_q + 8'h01;
                    end
                end
            end
            SAS_FORMAT: begin
                cnt_d = cnt_q + 10'h001;
                if (cnt_q + 10'h001 == 10'(SAS_FORMAT_PER)) begin
                    cnt_d = 10'h000;
                    if (smp_q != n_samples) begin
                        st_d = SAS_SAMPLE; // R9
                    end else begin
                        res_d = fmt(acc_q, ACCUMULATE_COUNT_SELECT_IN,
                                    LEFT_ALIGN_BIT_IN,
                                    RES_10BIT_IN); // R8 R16
                        rdy_d = 1'b1; // R8 R19 R10
                        evo_d = 1'b1; // R10
                        acc_d = 20'h00000;
                        smp_d = 8'h00;
                        if (FREE_RUN_IN) begin
                            st_d = SAS_START; // R2
                        end else begin
                            st_d = SAS_IDLE;
                            busy_d = 1'b0; // R17
                        end
                    end
                end
            end
            default: begin
                st_d = SAS_IDLE;
                busy_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            st_q <= SAS_IDLE;
            busy_q <= 1'b0;
            cnt_q <= 10'h000;
            smp_q <= 8'h00;
            acc_q <= 20'h00000;
            res_q <= SAS_RES_RESET;
            rdy_q <= 1'b0;
            evo_q <= 1'b0;
        end else begin
            st_q <= st_d;
            busy_q <= busy_d;
            cnt_q <= cnt_d;
            smp_q <= smp_d;
            acc_q <= acc_d;
            res_q <= res_d;
            rdy_q <= rdy_d;
            evo_q <= evo_d;
        end
    end

    assign START_CONVERSION_BIT_OUT = busy_q;
    assign SAMPLING_OUT = (st_q == SAS_SAMPLE);
    assign CONVERSION_RESULT_REG_OUT = res_q;
    assign RESULT_READY_FLAG_OUT = rdy_q;
    assign RESULT_READY_EVENT_OUT = evo_q;
    assign RESULT_READY_IRQ_OUT = rdy_q && RESULT_READY_INT_ENABLE_IN;

    chk_start_leaves_idle: assert property (@(posedge SYS_CLK_IN)
        disable iff (!RESETN_IN)
        (st_q == SAS_IDLE && trig) |=> st_q == SAS_START && busy_q) // R5
        else $error("trigger did not start conversion");

    chk_start_then_run: assert property (@(posedge SYS_CLK_IN)
        disable iff (!RESETN_IN)
        st_q == SAS_START |=> st_q inside {SAS_INIT, SAS_SAMPLE}) // R6
        else $error("start-up longer than allowed");

    chk_done_sets_flag: assert property (@(posedge SYS_CLK_IN)
        disable iff (!RESETN_IN)
        evo_q |-> rdy_q && $changed(st_q)) // R8
        else $error("completion without ready flag");

    chk_flag_set_wins: assert property (@(posedge SYS_CLK_IN)
        disable iff (!RESETN_IN)
        (evo_d && RESULT_READY_CLEAR_IN) |=> rdy_q) // R19
        else $error("ready lost to clear");

    chk_busy_until_done: assert property (@(posedge SYS_CLK_IN)
        disable iff (!RESETN_IN)
        $fell(busy_q) |-> $past(st_q) == SAS_FORMAT && st_q == SAS_IDLE) // R17
        else $error("start bit cleared early");

    chk_free_run_restart: assert property (@(posedge SYS_CLK_IN)
        disable iff (!RESETN_IN)
        (evo_d && FREE_RUN_IN) |=> st_q == SAS_START && busy_q) // R2
        else $error("free-running did not relaunch");

    chk_idle_clock_divider_select_clear: assert property (@(posedge SYS_CLK_IN)
        disable iff (!RESETN_IN)
        st_q == SAS_IDLE |-> !half_tick) // R6
        else $error("prescaler ran while idle");

    chk_format_two: assert property (@(posedge SYS_CLK_IN)
        disable iff (!RESETN_IN)
        $rose(st_q == SAS_FORMAT) |-> st_q == SAS_FORMAT [*2]
        ##1 st_q != SAS_FORMAT) // R7
        else $error("format phase not two cycles");

    chk_irq_holds: assert property (@(posedge SYS_CLK_IN)
        disable iff (!RESETN_IN)
        (rdy_q && !RESULT_READY_CLEAR_IN && !evo_d) |=> rdy_q) // R20
        else $error("ready flag dropped without clear");
endmodule : sas_sequencer

// *** bench/tb_top.sv ***
/*
 * tb_top: self-checking bench for the converter sequencer.
 * assumes sas_pkg is compiled first; drives ports 1 ns after each rising edge.
 */
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (a), (e)); end end
module tb_top import sas_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0, evt = 1'b0, evt_en = 1'b0, free = 1'b0;
    logic diff = 1'b0, ten = 1'b0, left = 1'b0, irq_en = 1'b0, clr = 1'b0;
    logic [SAS_CLOCK_DIVIDER_SELECT_W-1:0] psel = '0;
    logic [SAS_ACC_SEL_W-1:0] acc = '0;
    logic [SAS_DLY_W-1:0] dly = '0;
    logic [SAS_LEN_W-1:0] len = '0;
    logic [SAS_INIT_W-1:0] init = '0;
    logic [SAS_DATA_W-1:0] smp = '0;
    logic busy, sampling, flag, ev, irq;
    logic [SAS_RES_W-1:0] res;
    int error_cnt = 0;
    int tests_run = 0;
    int n, ns;
    // packed: diff, ten, left, raw word, expected result
    logic [31:0] fmt [6] = '{32'h1ABCABC0, 32'h4800F800, 32'h47FF07FF,
                             32'h2FFF03FF, 32'h6800FE00, 32'h3FFFFFC0};
    always #2 clk = ~clk;
    sas_sequencer dut (
        .SYS_CLK_IN(clk), .RESETN_IN(rst_n),
        .START_CONVERSION_BIT_WR_IN(wr), .START_EVENT_IN(evt),
        .START_EVENT_INPUT_ENABLE_IN(evt_en), .FREE_RUN_IN(free),
        .DIFFERENTIAL_IN(diff), .RES_10BIT_IN(ten),
        .LEFT_ALIGN_BIT_IN(left), .CLOCK_DIVIDER_SELECT_IN(psel),
        .ACCUMULATE_COUNT_SELECT_IN(acc), .SAMPLING_DELAY_FIELD_IN(dly),
        .SAMPLE_LENGTH_FIELD_IN(len), .INIT_DELAY_FIELD_IN(init),
        .RESULT_READY_INT_ENABLE_IN(irq_en), .RESULT_READY_CLEAR_IN(clr),
        .SAMPLE_IN(smp), .START_CONVERSION_BIT_OUT(busy),
        .SAMPLING_OUT(sampling), .CONVERSION_RESULT_REG_OUT(res),
        .RESULT_READY_FLAG_OUT(flag), .RESULT_READY_EVENT_OUT(ev),
        .RESULT_READY_IRQ_OUT(irq)
    );
    task automatic stop_test();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : step
    // mode 0 write trigger, 1 event trigger, 2 no trigger (free run)
    task automatic go(input int mode, output int cyc, output int scnt);
        int seen;
        seen = 0;
        cyc = 0;
        scnt = 0;
        if (mode == 0) wr = 1'b1;
        if (mode == 1) evt = 1'b1;
        clr = 1'b1;
        step(1);
        wr = 1'b0;
        clr = 1'b0;
        `CHK(flag, 1'b0)
        if (mode == 0) `CHK(busy, 1'b1)
        while (ev !== 1'b1) begin
            if (busy === 1'b1) seen = 1;
            else if (seen == 1) `CHK(busy, 1'b1)
            if (sampling === 1'b1) scnt++;
            cyc++;
            if (cyc > 40000) begin
                error_cnt++;
                stop_test();
            end
            step(1);
        end
        evt = 1'b0;
        `CHK(flag, 1'b1)
        `CHK(seen, 1)
    endtask : go
    // cycles from start bit to ready event, init delay in converter cycles
    function automatic int exp_cyc(int s, int k, int d, int l, int ini);
        return 2 + k * ((2 ** s) * (2 * (2 + d + l) + 27) + 2)
            + ini * (2 ** (s + 1));
    endfunction : exp_cyc
    task automatic chk_time(int got, int e, int tol);
        `CHK((got >= e - tol) && (got <= e + tol), 1'b1)
    endtask : chk_time
    initial begin
        step(12);
        rst_n = 1'b1;
        `CHK(res, SAS_RES_RESET)
        `CHK(busy, 1'b0)
        `CHK(flag, 1'b0)
        step(1);
        smp = 12'hABC;
        go(0, n, ns);
        `CHK(res, 16'h0ABC)
        chk_time(n, exp_cyc(0, 1, 0, 0, 0), 2);
        chk_time(ns, 4, 1);
        `CHK(irq, 1'b0)
        step(1);
        `CHK(ev, 1'b0)
        `CHK(busy, 1'b0)
        `CHK(flag, 1'b1)
        irq_en = 1'b1;
        step(1);
        `CHK(irq, 1'b1)
        clr = 1'b1;
        step(1);
        clr = 1'b0;
        `CHK(flag, 1'b0)
        `CHK(irq, 1'b0)
        for (int i = 0; i < 6; i++) begin
            {diff, ten, left} = fmt[i][30:28];
            smp = fmt[i][27:16];
            go(0, n, ns);
            `CHK(res, fmt[i][15:0])
            step(2);
        end
        {diff, ten, left} = 3'b000;
        smp = 12'hFFF;
        acc = 3'h1;
        go(0, n, ns);
        `CHK(res, 16'h1FFE)
        chk_time(n, exp_cyc(0, 2, 0, 0, 0), 3);
        step(2);
        acc = 3'h0;
        psel = 4'h1;
        dly = 4'h1;
        len = 8'h02;
        init = 8'h03;
        go(0, n, ns);
        chk_time(n, exp_cyc(1, 1, 1, 2, 3), 4);
        chk_time(ns, 20, 2);
        `CHK(res, 16'h0FFF)
        step(2);
        {psel, dly, len, init} = '0;
        evt = 1'b1;
        step(10);
        `CHK(busy, 1'b0)
        evt = 1'b0;
        step(4);
        evt_en = 1'b1;
        smp = 12'h123;
        go(1, n, ns);
        `CHK(res, 16'h0123)
        step(4);
        free = 1'b1;
        step(10);
        `CHK(busy, 1'b0)
        go(0, n, ns);
        step(1);
        `CHK(busy, 1'b1)
        smp = 12'h456;
        go(2, n, ns);
        `CHK(res, 16'h0456)
        free = 1'b0;
        go(2, n, ns);
        step(2);
        `CHK(busy, 1'b0)
        stop_test();
    end
endmodule : tb_top
